// File: hw/pwr_sequencer.sv
// Power sequencer inside the device: converter, monitor, processor enables.
// Assumes enable pins and sensed level come from outside; threshold is
// written by the serial control block on CLOCK.
`timescale 1ns/1ps
`default_nettype none
module pwr_sequencer
   import pwrseq_pkg::*;
#(
   parameter int W = VOLT_W,
   parameter int FW = FILT_W
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Enable pins from the controller
   input wire logic CONVERTER_ENABLE_PIN,
   input wire logic PROCESSOR_WAKE_ENABLE,
   // Sensed supply sample
   input wire logic [W-1:0] SENSED_SUPPLY_INPUT,
   // Threshold write from serial control block
   input wire logic THRESH_WE,
   input wire logic [W-1:0] THRESH_DATA,
   // Serial control requests
   input wire logic CTRL_REQ,
   // Outputs
   output logic POWER_GOOD_FLAG,
   output logic CONVERTER_ON,
   output logic MONITOR_ON,
   output logic PROCESSOR_ON,
   output logic CTRL_ACCEPT,
   output logic CTRL_REFUSED,
   output logic [W-1:0] THRESHOLD
);
   // Smallest widths the logic can serve
   localparam int MIN_W = 2;
   localparam int MIN_FW = 1;

   // Refuse parameter values the filter or compare cannot serve
   generate
      if (W < MIN_W || FW < MIN_FW || FW > FILT_W) begin : g_bad_params
         $error("pwr_sequencer: bad parameters");
      end
   endgenerate

   // Filter constants at the filter's own width
   localparam logic [FW-1:0] FILT_ONE = FW'(1);
   localparam logic [FW-1:0] FILT_TOP = FILT_MAX[FW-1:0];
   localparam logic [FW-1:0] FILT_CLR = FILT_ZERO[FW-1:0];

   // Converter enable pin: two stages before any logic
   logic conv_s1_ff;
   logic conv_s2_ff;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         conv_s1_ff <= 1'b0;
         conv_s2_ff <= 1'b0;
      end else begin
         conv_s1_ff <= CONVERTER_ENABLE_PIN;
         conv_s2_ff <= conv_s1_ff;
      end
   end

   // Processor wake pin: two stages before any logic
   logic proc_s1_ff;
   logic proc_s2_ff;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         proc_s1_ff <= 1'b0;
         proc_s2_ff <= 1'b0;
      end else begin
         proc_s1_ff <= PROCESSOR_WAKE_ENABLE;
         proc_s2_ff <= proc_s1_ff;
      end
   end

   // Sensed word: two stages, plus a third for the steadiness test
   logic [W-1:0] sense_s1_ff;
   logic [W-1:0] sense_s2_ff;
   logic [W-1:0] sense_s3_ff;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sense_s1_ff <= '0;
         sense_s2_ff <= '0;
         sense_s3_ff <= '0;
      end else begin
         sense_s1_ff <= SENSED_SUPPLY_INPUT;
         sense_s2_ff <= sense_s1_ff;
         sense_s3_ff <= sense_s2_ff;
      end
   end

   // A word is taken only when two settled samples agree,
   // so a word torn by the crossing never reaches the compare
   logic [W-1:0] sense_ok_ff;
   logic [W-1:0] nxt_sense_ok;
   wire sense_steady = (sense_s3_ff == sense_s2_ff);
   assign nxt_sense_ok = sense_steady ? sense_s2_ff : sense_ok_ff;

   // Held sensed word
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sense_ok_ff <= '0;
      end else begin
         sense_ok_ff <= nxt_sense_ok;
      end
   end

   // Mode decode from the settled pins
   mode_t mode;
   wire conv_run = conv_s2_ff | proc_s2_ff;
   wire proc_run = proc_s2_ff;
   wire mon_run = conv_s2_ff;
   assign mode = proc_run ? MODE_FULL : (conv_run ? MODE_CONV_ONLY : MODE_OFF);
   wire serial_awake = (mode == MODE_FULL);

   // Threshold register, only writable while serial block is awake
   logic [W-1:0] thresh_ff;
   logic [W-1:0] nxt_thresh;
   wire thresh_take = THRESH_WE && serial_awake;
   assign nxt_thresh = thresh_take ? THRESH_DATA : thresh_ff;

   // Threshold storage; a refused write leaves it unchanged
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         thresh_ff <= THRESH_RST;
      end else begin
         thresh_ff <= nxt_thresh;
      end
   end

   // Comparison of settled word with threshold
   logic good_raw;
   supply_monitor #(.W(W)) supply_monitor_inst (
      .clk(CLOCK),
      .rst(RST),
      .active(mon_run),
      .level(sense_ok_ff),
      .threshold(thresh_ff),
      .good(good_raw)
   );

   // Power-good with a short rise filter against sample noise
   logic [FW-1:0] filt_ff;
   logic [FW-1:0] nxt_filt;
   wire filt_full = (filt_ff == FILT_TOP);
   wire [FW-1:0] filt_inc = filt_ff + FILT_ONE;
   assign nxt_filt = !good_raw ? FILT_CLR : (filt_full ? filt_ff : filt_inc);

   // Filter counter, cleared by any low compare
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         filt_ff <= FILT_CLR;
      end else begin
         filt_ff <= nxt_filt;
      end
   end

   // drop at once, rise after filter
   logic good_ff;
   logic nxt_good;
   assign nxt_good = good_raw && filt_full;

   // Power-good output register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         good_ff <= 1'b0;
      end else begin
         good_ff <= nxt_good;
      end
   end

   // Serial control gating
   logic accept_ff;
   logic refuse_ff;
   wire nxt_accept = CTRL_REQ && serial_awake;
   wire nxt_refuse = CTRL_REQ && !serial_awake;

   // One-cycle answer to each request
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         accept_ff <= 1'b0;
         refuse_ff <= 1'b0;
      end else begin
         accept_ff <= nxt_accept;
         refuse_ff <= nxt_refuse;
      end
   end

   // Block enables shown at the ports
   logic conv_ff;
   logic mon_ff;
   logic proc_ff;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         conv_ff <= 1'b0;
         mon_ff <= 1'b0;
         proc_ff <= 1'b0;
      end else begin
         conv_ff <= conv_run;
         mon_ff <= mon_run;
         proc_ff <= proc_run;
      end
   end

   // Ports straight from the registers
   assign POWER_GOOD_FLAG = good_ff;
   assign CONVERTER_ON = conv_ff;
   assign MONITOR_ON = mon_ff;
   assign PROCESSOR_ON = proc_ff;
   assign CTRL_ACCEPT = accept_ff;
   assign CTRL_REFUSED = refuse_ff;
   assign THRESHOLD = thresh_ff;
endmodule // pwr_sequencer
`default_nettype wire

// File: hw/pwrseq_pkg.sv
// Package for the converter and processor power sequencer.
// Assumes a 200 MHz CLOCK; all constants shared by the design files.
package pwrseq_pkg;
   // Clock rate and settling time
   localparam int CLK_MHZ = 200;
   localparam int SETTLE_US = 1000;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   // Monitor widths
   localparam int VOLT_W = 12;
   localparam int FILT_W = 4;
   localparam logic [VOLT_W-1:0] THRESH_RST = 12'h800;
   localparam logic [FILT_W-1:0] FILT_MAX = 4'hF;
   localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;
   // Device power modes
   typedef enum {MODE_OFF, MODE_CONV_ONLY, MODE_FULL} mode_t;
endpackage

// File: hw/supply_monitor.sv
// Supply monitor: compares a synchronised sensed sample with a threshold.
// Assumes sample and threshold already on the CLOCK domain.
`timescale 1ns/1ps
`default_nettype none
module supply_monitor
   import pwrseq_pkg::*;
#(
   parameter int W = VOLT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic active,
   input wire logic [W-1:0] level,
   input wire logic [W-1:0] threshold,
   // Result
   output logic good
);
   logic good_ff;
   logic nxt_good;
   wire above = (level >= threshold);

   assign nxt_good = active & above;
   assign good = good_ff;

   // Registered comparison
   always_ff @(posedge clk) begin
      if (rst) begin
         good_ff <= 1'b0;
      end else begin
         good_ff <= nxt_good;
      end
   end
endmodule // supply_monitor
`default_nettype wire

// File: tb/pwr_controller.sv
// Controller model driving the two enable pins.
// Assumes the CLOCK domain and the device's power-good flag.
`timescale 1ns/1ps
`default_nettype none
module pwr_controller #(parameter int SETTLE = 10) (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic good,
   // Enable pins
   output logic cen,
   output logic wake
);
   int cnt_ff;
   logic wake_ff;
   assign cen = start;
   assign wake = wake_ff;
   always_ff @(posedge clk) begin
      if (rst || !start || !good) begin
         cnt_ff <= 0;
         wake_ff <= 1'h0;
      end else if (cnt_ff < SETTLE) begin
         cnt_ff <= cnt_ff + 1;
      end else begin
         wake_ff <= 1'h1;
      end
   end
endmodule // pwr_controller
`default_nettype wire

// File: tb/pwr_sequencer_bench.sv
// Bench for the power sequencer with the controller model.
// Assumes 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pwr_sequencer_bench;
   import pwrseq_pkg::*;
   logic clock = 1'h0, rst = 1'h1, start = 1'h0, we = 1'h0, req = 1'h0;
   logic [VOLT_W-1:0] sense = 12'h7FF, data = 12'h000, thr;
   logic cen, wake, pg, con, mon, pon, acc, refused;
   int n_errors = 0, n_checks = 0, cycles = 0;
   pwr_controller pwr_controller_inst (.clk(clock), .rst(rst), .start(start), .good(pg), .cen(cen), .wake(wake));
   pwr_sequencer pwr_sequencer_inst (.CLOCK(clock), .RST(rst), .CONVERTER_ENABLE_PIN(cen),
      .PROCESSOR_WAKE_ENABLE(wake), .SENSED_SUPPLY_INPUT(sense), .THRESH_WE(we), .THRESH_DATA(data), .CTRL_REQ(req),
      .POWER_GOOD_FLAG(pg), .CONVERTER_ON(con), .MONITOR_ON(mon), .PROCESSOR_ON(pon), .CTRL_ACCEPT(acc),
      .CTRL_REFUSED(refused), .THRESHOLD(thr));
   always #2.5 clock = ~clock;
   task summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [VOLT_W-1:0] got, input logic [VOLT_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One request pulse, answer seen next cycle
   task pulse_req(input logic [1:0] exp);
      req = 1'h1;
      @(negedge clock) req = 1'h0;
      chk({acc, refused}, exp);
      @(negedge clock);
   endtask
   task t_reset;
      chk(thr, 12'h800);
      chk({con, mon, pon, pg}, 4'h0);
   endtask
   task t_conv_only;
      start = 1'h1;
      repeat (40) @(negedge clock);
      chk({con, mon, pon, pg}, 4'hC);
      pulse_req(2'h1);
      we = 1'h1;
      data = 12'h400;
      @(negedge clock) we = 1'h0;
      chk(thr, 12'h800);
   endtask
   // Refused write while asleep, then recovery and wake again
   task t_restart;
      we = 1'h1;
      data = 12'h700;
      @(negedge clock) we = 1'h0;
      chk(thr, 12'hA00);
      sense = 12'hB00;
      repeat (100) if (!pon) @(negedge clock);
      chk({con, mon, pon, pg}, 4'hF);
   endtask
   task t_full;
      sense = 12'h800;
      repeat (80) if (!pon) @(negedge clock);
      chk({con, mon, pon, pg}, 4'hF);
      pulse_req(2'h2);
   endtask
   task t_drop;
      we = 1'h1;
      data = 12'hA00;
      @(negedge clock) we = 1'h0;
      chk(thr, 12'hA00);
      repeat (20) if (pg) @(negedge clock);
      chk(pg, 1'h0);
      repeat (10) @(negedge clock);
      chk({con, mon, pon}, 3'h6);
   endtask
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(negedge clock);
      rst = 1'h0;
      @(negedge clock);
      t_reset();
      t_conv_only();
      t_full();
      t_drop();
      t_restart();
      summarize();
   end
endmodule // pwr_sequencer_bench
`default_nettype wire

// File: tb/pwr_sequencer_properties.sv
// Port checker for the power sequencer.
// Assumes bind onto pwr_sequencer; enable pins reach outputs in 3 edges, CTRL_REQ in 1.
`timescale 1ns/1ps
`default_nettype none
module pwr_sequencer_properties (
   // Clock, reset and pins
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CONVERTER_ENABLE_PIN,
   input wire logic PROCESSOR_WAKE_ENABLE,
   input wire logic CTRL_REQ,
   // Device outputs
   input wire logic POWER_GOOD_FLAG,
   input wire logic CONVERTER_ON,
   input wire logic MONITOR_ON,
   input wire logic PROCESSOR_ON,
   input wire logic CTRL_ACCEPT,
   input wire logic CTRL_REFUSED
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   // Output relations
   AST_MON_PIN: assert property (MONITOR_ON |-> $past(CONVERTER_ENABLE_PIN, 3)) else $error("monitor without pin");
   AST_CONV_PIN: assert property (CONVERTER_ON |-> $past(CONVERTER_ENABLE_PIN, 3) || $past(PROCESSOR_WAKE_ENABLE, 3))
      else $error("converter without pin");
   AST_PROC_PIN: assert property (PROCESSOR_ON |-> $past(PROCESSOR_WAKE_ENABLE, 3)) else $error("processor no pin");
   AST_PROC_CONV: assert property (PROCESSOR_ON |-> CONVERTER_ON) else $error("processor without converter");
   AST_PG_MON: assert property ($rose(POWER_GOOD_FLAG) |-> MONITOR_ON) else $error("good without monitor");
   AST_REQ_ANS: assert property (CTRL_REQ |=> CTRL_ACCEPT != CTRL_REFUSED) else $error("request unanswered");
   AST_ACC_REQ: assert property (CTRL_ACCEPT |-> $past(CTRL_REQ)) else $error("accept without request");
   AST_REF_REQ: assert property (CTRL_REFUSED |-> $past(CTRL_REQ)) else $error("refusal without request");
   AST_ACC_AWAKE: assert property (CTRL_ACCEPT |-> PROCESSOR_ON) else $error("accept while processor off");
   AST_PG_OFF: assert property ($fell(MONITOR_ON) |=> !POWER_GOOD_FLAG) else $error("good after monitor off");
endmodule // pwr_sequencer_properties
bind pwr_sequencer pwr_sequencer_properties pwr_sequencer_properties_inst (.CLOCK, .RST, .CONVERTER_ENABLE_PIN,
   .PROCESSOR_WAKE_ENABLE, .CTRL_REQ, .POWER_GOOD_FLAG, .CONVERTER_ON, .MONITOR_ON, .PROCESSOR_ON, .CTRL_ACCEPT,
   .CTRL_REFUSED);
`default_nettype wire
